//--- hw/dcsm_map.svh
// Register offsets, field positions and reset values of the semaphore/mailbox block.
// Assumes byte addresses on a 32-bit APB word bus.
`ifndef DCSM_MAP_SVH
`define DCSM_MAP_SVH
`define DCSM_SLOT_BASE 12'h000
`define DCSM_SLOT_LAST 12'h01c
`define DCSM_DB_MAIN 12'h040
`define DCSM_MB_ZERO 12'h044
`define DCSM_DB_HELPER 12'h048
`define DCSM_MB_ONE 12'h04c
`define DCSM_MIRROR 12'h100
`define DCSM_DB_FLAG_BIT 16
`define DCSM_DB_EN_BIT 0
`define DCSM_RESET_WORD 32'h0000_0000
`define DCSM_NUM_SLOTS 8
`endif

//--- hw/dcsm_pkg.sv
// Types shared by the semaphore/mailbox block and its bench.
// Assumes one APB3-style request and answer per core.
package dcsm_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dcsm_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dcsm_apb_rsp_t;

	typedef struct packed {
		logic [7:0] slot;
		logic main_flag;
		logic main_en;
		logic [31:0] mbox0;
		logic helper_flag;
		logic helper_en;
		logic [31:0] mbox1;
	} dcsm_regs_t;
endpackage : dcsm_pkg

//--- hw/dcsm_top.sv
// Eight semaphore slots, two mailbox words and two doorbells for two cores.
// Assumes both cores are APB masters on pclk; block reset comes from pclk logic.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "dcsm_map.svh"

// Summary of operation
// (RQ1) Slot bit 0 is the flag, writing 0 releases; other bits read zero.
// (RQ2) Slot read returns old flag; a free slot is taken by that read.
// (RQ3) Eight independent slots, each settable and clearable by either core.
// (RQ4) Mirror register shows slot n at bit n live; upper bits zero.
// (RQ5) Reading the mirror never changes any slot.
// (RQ6) Main doorbell interrupt is raised while its flag and enable are set.
// (RQ7) Main doorbell enable at bit 0; other bits besides 16 read zero.
// (RQ8) Helper doorbell interrupt is raised while its flag and enable are set.
// (RQ9) Helper software clears its doorbell enable after taking the interrupt.
// (RQ10) Main handler clears flag or enable to drop its interrupt.
// (RQ11) Both mailbox words are plain 32-bit read/write, reset to zero.
// (RQ12) Sender writes the mailbox first, then rings the doorbell.
// (RQ13) Software dedicates one mailbox per direction and handles collisions.
// (RQ14) Block reset control clears slots, doorbells and mailboxes.
// (RQ15) Same-cycle accesses are serialized; only one read can acquire a slot.
module dcsm_top #(
	// Slot count; map and state word are laid out for this many
	parameter int NUM_SLOTS = `DCSM_NUM_SLOTS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic semaphore_block_reset_control,
	// Main core APB port
	input wire dcsm_pkg::dcsm_apb_req_t main_req,
	output dcsm_pkg::dcsm_apb_rsp_t main_rsp,
	// Helper core APB port
	input wire dcsm_pkg::dcsm_apb_req_t helper_req,
	output dcsm_pkg::dcsm_apb_rsp_t helper_rsp,
	// Doorbell interrupts
	output logic irq_main_core,
	output logic irq_helper_core
);

	dcsm_pkg::dcsm_regs_t regs;
	dcsm_pkg::dcsm_regs_t after_main;
	dcsm_pkg::dcsm_regs_t next_regs;
	logic go_m;
	logic go_h;
	logic [31:0] rd_m;
	logic [31:0] rd_h;
	logic [2:0] idx_m;
	logic [2:0] idx_h;

	// Three index bits and an eight-bit mirror limit the slot count
	if (NUM_SLOTS != 8) begin : g_slot_check
		$error("dcsm_top supports eight semaphore slots only");
	end

	function automatic logic is_slot(input logic [11:0] a);
		return (a <= `DCSM_SLOT_LAST) && (a[1:0] == 2'b00);
	endfunction : is_slot

	function automatic logic is_mapped(input logic [11:0] a);
		logic hit;
		hit = is_slot(a);
		hit = hit || (a == `DCSM_DB_MAIN) || (a == `DCSM_MB_ZERO);
		hit = hit || (a == `DCSM_DB_HELPER) || (a == `DCSM_MB_ONE);
		hit = hit || (a == `DCSM_MIRROR);
		return hit;
	endfunction : is_mapped

	function automatic logic [31:0] read_word(
		input dcsm_pkg::dcsm_regs_t s,
		input logic [11:0] a
	);
		logic [31:0] w;
		w = `DCSM_RESET_WORD;
		if (is_slot(a)) begin
			// (RQ1) flag in bit 0
			w[0] = s.slot[a[4:2]];
		end else if (a == `DCSM_DB_MAIN) begin
			// (RQ7) enable and flag only
			w[`DCSM_DB_FLAG_BIT] = s.main_flag;
			w[`DCSM_DB_EN_BIT] = s.main_en;
		end else if (a == `DCSM_DB_HELPER) begin
			w[`DCSM_DB_FLAG_BIT] = s.helper_flag;
			w[`DCSM_DB_EN_BIT] = s.helper_en;
		end else if (a == `DCSM_MB_ZERO) begin
			w = s.mbox0;
		end else if (a == `DCSM_MB_ONE) begin
			w = s.mbox1;
		end else if (a == `DCSM_MIRROR) begin
			// (RQ4) live copy of all slots
			w[7:0] = s.slot;
		end
		return w;
	endfunction : read_word

	function automatic dcsm_pkg::dcsm_regs_t apply(
		input dcsm_pkg::dcsm_regs_t s,
		input logic go,
		input dcsm_pkg::dcsm_apb_req_t r
	);
		dcsm_pkg::dcsm_regs_t n;
		n = s;
		if (go && r.pwrite) begin
			if (is_slot(r.paddr)) begin
				// (RQ1) write 0 releases the slot
				n.slot[r.paddr[4:2]] = r.pwdata[0];
			end else if (r.paddr == `DCSM_DB_MAIN) begin
				// (RQ6) flag and enable writable
				n.main_flag = r.pwdata[`DCSM_DB_FLAG_BIT];
				n.main_en = r.pwdata[`DCSM_DB_EN_BIT];
			end else if (r.paddr == `DCSM_DB_HELPER) begin
				// (RQ8) flag and enable writable
				n.helper_flag = r.pwdata[`DCSM_DB_FLAG_BIT];
				n.helper_en = r.pwdata[`DCSM_DB_EN_BIT];
			end else if (r.paddr == `DCSM_MB_ZERO) begin
				// (RQ11) plain word
				n.mbox0 = r.pwdata;
			end else if (r.paddr == `DCSM_MB_ONE) begin
				n.mbox1 = r.pwdata;
			end
		end else if (go && is_slot(r.paddr)) begin
			// (RQ2) reading a free slot takes it
			// (RQ5) mirror reads never acquire
			n.slot[r.paddr[4:2]] = 1'b1;
		end
		return n;
	endfunction : apply

	// Access happens in the first access cycle; pready follows one edge later
	assign go_m = main_req.psel && main_req.penable && !main_rsp.pready;
	assign go_h = helper_req.psel && helper_req.penable && !helper_rsp.pready;
	assign idx_m = main_req.paddr[4:2];
	assign idx_h = helper_req.paddr[4:2];

	// (RQ15) main core first, helper sees its result
	always_comb begin
		after_main = apply(regs, go_m, main_req);
		next_regs = apply(after_main, go_h, helper_req);
		rd_m = read_word(regs, main_req.paddr);
		rd_h = read_word(after_main, helper_req.paddr);
	end

	// (RQ3) all slots held in one state word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs <= '0;
		end else if (semaphore_block_reset_control) begin
			// (RQ14) block reset clears the whole state word
			regs <= '0;
		end else begin
			regs <= next_regs;
		end
	end

	// Main core answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_rsp <= '0;
		end else begin
			main_rsp.pready <= go_m;
			main_rsp.pslverr <= go_m && !is_mapped(main_req.paddr);
			if (go_m && !main_req.pwrite) begin
				main_rsp.prdata <= rd_m;
			end
		end
	end

	// Helper core answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			helper_rsp <= '0;
		end else begin
			helper_rsp.pready <= go_h;
			helper_rsp.pslverr <= go_h && !is_mapped(helper_req.paddr);
			if (go_h && !helper_req.pwrite) begin
				helper_rsp.prdata <= rd_h;
			end
		end
	end

	// Interrupts registered from state; one cycle behind the flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_main_core <= 1'b0;
			irq_helper_core <= 1'b0;
		end else begin
			// (RQ6) main doorbell level
			irq_main_core <= regs.main_flag && regs.main_en;
			// (RQ8) helper doorbell level
			irq_helper_core <= regs.helper_flag && regs.helper_en;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence free_slot_read_s;
		go_m && !main_req.pwrite && is_slot(main_req.paddr)
			&& !regs.slot[idx_m] && !semaphore_block_reset_control
			&& !(go_h && helper_req.pwrite && helper_req.paddr == main_req.paddr);
	endsequence

	sequence acquired_s;
		main_rsp.pready && (main_rsp.prdata == 32'h0000_0000)
			&& regs.slot[$past(idx_m)];
	endsequence

	acquire_free_a: assert property ( // RQ2
		free_slot_read_s |=> acquired_s
	) else $error("free slot read did not acquire");

	slot_upper_zero_a: assert property ( // RQ1
		go_m && !main_req.pwrite && is_slot(main_req.paddr)
			|=> main_rsp.prdata[31:1] == 31'h0000_0000
	) else $error("slot read has upper bits set");

	release_slot_a: assert property ( // RQ1
		go_h && helper_req.pwrite && is_slot(helper_req.paddr)
			&& !semaphore_block_reset_control
			|=> regs.slot[$past(idx_h)] == $past(helper_req.pwdata[0])
	) else $error("slot write not stored");

	mirror_live_a: assert property ( // RQ4
		go_m && !main_req.pwrite && main_req.paddr == `DCSM_MIRROR
			|=> main_rsp.prdata == {24'h00_0000, $past(regs.slot)}
	) else $error("mirror does not match slots");

	mirror_no_acquire_a: assert property ( // RQ5
		go_m && !go_h && main_req.paddr == `DCSM_MIRROR
			&& !semaphore_block_reset_control
			|=> regs.slot == $past(regs.slot)
	) else $error("mirror read changed a slot");

	main_irq_a: assert property ( // RQ6
		regs.main_flag && regs.main_en |=> irq_main_core
	) else $error("main doorbell interrupt missing");

	main_db_bits_a: assert property ( // RQ7
		go_m && !main_req.pwrite && main_req.paddr == `DCSM_DB_MAIN
			|=> main_rsp.prdata[15:1] == 15'h0000
			&& main_rsp.prdata[31:17] == 15'h0000
	) else $error("main doorbell reserved bits set");

	helper_irq_a: assert property ( // RQ8
		!(regs.helper_flag && regs.helper_en) |=> !irq_helper_core
	) else $error("helper interrupt without flag and enable");

	mailbox_hold_a: assert property ( // RQ11
		!go_m && !go_h && !semaphore_block_reset_control
			|=> $stable(regs.mbox0) && $stable(regs.mbox1)
	) else $error("mailbox changed without a write");

	block_reset_a: assert property ( // RQ14
		semaphore_block_reset_control |=> regs == '0
	) else $error("block reset left state");

	serialize_a: assert property ( // RQ15
		go_m && go_h && !main_req.pwrite && !helper_req.pwrite
			&& is_slot(main_req.paddr) && main_req.paddr == helper_req.paddr
			&& !regs.slot[idx_m]
			|=> !main_rsp.prdata[0] && helper_rsp.prdata[0]
	) else $error("both cores acquired one slot");

	taken_read_a: assert property ( // RQ2
		go_m && !main_req.pwrite && is_slot(main_req.paddr) && regs.slot[idx_m]
			|=> main_rsp.prdata == 32'h0000_0001
	) else $error("taken slot read did not return one");

	helper_acquire_a: assert property ( // RQ3
		go_h && !helper_req.pwrite && is_slot(helper_req.paddr)
			&& !after_main.slot[idx_h] && !semaphore_block_reset_control
			|=> !helper_rsp.prdata[0] && regs.slot[$past(idx_h)]
	) else $error("helper core could not acquire a free slot");

	mirror_read_only_a: assert property ( // RQ4
		go_m && main_req.pwrite && main_req.paddr == `DCSM_MIRROR
			&& !go_h && !semaphore_block_reset_control
			|=> regs == $past(regs)
	) else $error("write to the mirror changed state");

	mailbox_read_a: assert property ( // RQ11
		go_m && !main_req.pwrite && main_req.paddr == `DCSM_MB_ZERO
			|=> main_rsp.prdata == $past(regs.mbox0)
	) else $error("mailbox read returned a different word");

	main_irq_off_a: assert property ( // RQ6
		!(regs.main_flag && regs.main_en) |=> !irq_main_core
	) else $error("main interrupt without flag and enable");

	helper_irq_on_a: assert property ( // RQ8
		regs.helper_flag && regs.helper_en |=> irq_helper_core
	) else $error("helper doorbell interrupt missing");

	reset_irq_low_a: assert property ( // RQ14
		semaphore_block_reset_control |=> ##1 (!irq_main_core && !irq_helper_core)
	) else $error("interrupt stayed up after block reset");

endmodule : dcsm_top

//--- bench/dcsm_core_model.sv
// One processor core seen as an APB master of the semaphore block.
// Assumes the bench calls xfer one transfer at a time per instance.
`timescale 1ns/1ns
module dcsm_core_model (
	// Clock
	input wire logic pclk,
	// APB request and answer
	output dcsm_pkg::dcsm_apb_req_t req,
	input wire dcsm_pkg::dcsm_apb_rsp_t rsp,
	// Wait for the answer ran out
	output logic hung
);
	initial begin
		req = '0;
		hung = 1'b0;
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		hung <= (rsp.pready !== 1'b1);
		// Released lines flip so stale values never pass for real ones
		req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
	endtask : xfer
endmodule : dcsm_core_model

//--- bench/test_dcsm_top.sv
// Self-checking bench: two core models share the block through its two ports.
// Assumes main core goes first in same-cycle conflicts and reads complete on pready.
`timescale 1ns/1ns
module test_dcsm_top;
	logic pclk, presetn, blk, irq_m, irq_h, hm, hh;
	dcsm_pkg::dcsm_apb_req_t mreq, hreq;
	dcsm_pkg::dcsm_apb_rsp_t mrsp, hrsp;
	logic [32:0] qm[$], qh[$], em, eh;
	logic [31:0] d;
	logic [11:0] a;
	int n_mismatch = 0, n_tests = 0, seed, i;

	dcsm_top DUT (.pclk(pclk), .presetn(presetn), .semaphore_block_reset_control(blk),
		.main_req(mreq), .main_rsp(mrsp), .helper_req(hreq), .helper_rsp(hrsp),
		.irq_main_core(irq_m), .irq_helper_core(irq_h));
	dcsm_core_model u_main (.pclk(pclk), .req(mreq), .rsp(mrsp), .hung(hm));
	dcsm_core_model u_help (.pclk(pclk), .req(hreq), .rsp(hrsp), .hung(hh));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] e);
		n_tests++;
		if (seen !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, e, seen);
		end
	endtask : chk

	task automatic rd(input bit h, input logic [11:0] ad, input logic [32:0] e);
		if (h) begin
			qh.push_back(e);
			u_help.xfer(1'b0, ad, 32'h0);
		end else begin
			qm.push_back(e);
			u_main.xfer(1'b0, ad, 32'h0);
		end
	endtask : rd

	task automatic wr(input bit h, input logic [11:0] ad, input logic [31:0] dd);
		if (h) u_help.xfer(1'b1, ad, dd);
		else u_main.xfer(1'b1, ad, dd);
	endtask : wr

	task automatic chk_irq(input logic [1:0] e);
		@(posedge pclk);
		#1 chk("irq", {31'h0, irq_h, irq_m}, {31'h0, e});
	endtask : chk_irq

	task print_verdict;
		$display("compares %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	// Error flag only: a refused read returns zero prdata, which is not compared
	always @(posedge pclk) begin
		if (mrsp.pready === 1'b1 && !mreq.pwrite) begin
			em = qm.pop_front();
			chk("main", {mrsp.pslverr, em[32] ? em[31:0] : mrsp.prdata}, em);
		end
		if (hrsp.pready === 1'b1 && !hreq.pwrite) begin
			eh = qh.pop_front();
			chk("helper", {hrsp.pslverr, eh[32] ? eh[31:0] : hrsp.prdata}, eh);
		end
	end

	always @(posedge hm or posedge hh) begin
		n_mismatch++;
		print_verdict;
	end

	initial begin
		presetn = 1'b0;
		blk = 1'b0;
		seed = 35;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(0, 12'h100, 33'h0);
		for (i = 0; i < 4; i++) rd(i[0], 12'h040 + 12'(4 * i), 33'h0);
		rd(1, 12'h0f0, 33'h1_0000_0000);
		rd(0, 12'h002, 33'h1_0000_0000);
		$display("done reset values");
		for (i = 0; i < 8; i++) begin
			rd(i[0], 12'(4 * i), 33'h0);
			rd(!i[0], 12'(4 * i), 33'h1);
			rd(0, 12'h100, 33'((33'h2 << i) - 33'h1));
		end
		rd(1, 12'h100, 33'hff);
		wr(0, 12'h01c, 32'hffff_fffe);
		rd(1, 12'h100, 33'h7f);
		rd(1, 12'h01c, 33'h0);
		wr(1, 12'h00c, 32'h0);
		fork
			rd(0, 12'h00c, 33'h0);
			rd(1, 12'h00c, 33'h1);
		join
		$display("done slots");
		for (i = 0; i < 2; i++) begin
			d = $random(seed);
			a = 12'h044 + 12'(8 * i);
			// Mailbox zero carries main to helper, one the reverse
			wr(i[0], a, d);
			wr(i[0], 12'h048 - 12'(8 * i), 32'hffff_ffff);
			chk_irq(i[0] ? 2'b01 : 2'b10);
			rd(!i[0], a, {1'b0, d});
			a = 12'h048 - 12'(8 * i);
			rd(!i[0], a, 33'h0_0001_0001);
			wr(!i[0], a, 32'h0001_0000);
			chk_irq(2'b00);
			wr(i[0], a, 32'h0001_0001);
			chk_irq(i[0] ? 2'b01 : 2'b10);
			wr(!i[0], a, 32'h0000_0001);
			chk_irq(2'b00);
		end
		$display("done doorbells");
		wr(0, 12'h048, 32'h0001_0001);
		chk_irq(2'b10);
		@(posedge pclk);
		blk <= 1'b1;
		@(posedge pclk);
		blk <= 1'b0;
		chk_irq(2'b00);
		rd(0, 12'h100, 33'h0);
		rd(1, 12'h04c, 33'h0);
		rd(1, 12'h040, 33'h0);
		rd(0, 12'h048, 33'h0);
		rd(0, 12'h044, 33'h0);
		$display("done block reset");
		@(posedge pclk);
		print_verdict;
	end
endmodule : test_dcsm_top
